// ==== core/stap_pkg.sv ====
package stap_pkg;

  // Instruction register
  localparam int unsigned IR_W            = 3;
  localparam logic [2:0]  OP_CLK_EXTEST   = 3'h0;
  localparam logic [2:0]  OP_IDCODE       = 3'h1;
  localparam logic [2:0]  OP_SAMPLE_Z     = 3'h2;
  localparam logic [2:0]  OP_RSVD_3       = 3'h3;
  localparam logic [2:0]  OP_SAMPLE_PRE   = 3'h4;
  localparam logic [2:0]  OP_RSVD_5       = 3'h5;
  localparam logic [2:0]  OP_RSVD_6       = 3'h6;
  localparam logic [2:0]  OP_BYPASS       = 3'h7;
  localparam logic [2:0]  IR_CAPTURE_VAL  = 3'h1;
  localparam logic [2:0]  IR_RESET_VAL    = OP_IDCODE;

  // Data registers
  localparam int unsigned ID_W            = 32;
  localparam int unsigned BSR_LEN         = 119;
  // Identification value is arbitrary; bit 0 set as the scan convention asks
  localparam logic [31:0] DEVICE_CODE_ROM = 32'h0000_0001;

  // TAP controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } stap_state_t;

endpackage

// ==== core/stap_tap.sv ====
`timescale 1ns/1ps
// Operation
// - In IDCODE, Capture-DR copies the identification ROM into the 32-bit ID register.
// - In IDCODE, Shift-DR shifts the ID register from TDI to TDO.
// - IDCODE becomes active at power-up and on entering Test-Logic-Reset.
// - Output-floating sample holds all SRAM output drivers high-impedance.
// - Output-floating sample shifts the boundary register between TDI and TDO in Shift-DR.
// - Opcodes: 000 ext-test, 001 IDCODE, 010 float-sample, 100 sample, 111 bypass.
// - Three-bit instruction; Capture-IR loads 01 low bits; takes effect at Update-IR.
// - Five rising TCK edges with TMS high reach Test-Logic-Reset.
// - Registers capture TDI on rising TCK and drive TDO on falling TCK.
module stap_tap (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         tck,
  input  wire logic         tms,
  input  wire logic         tdi,
  output logic              tdo,
  output logic              tdoEn,
  input  wire logic [118:0] sramPins,
  output logic              sramOutFloat
);

  stap_pkg::stap_state_t state_r;
  stap_pkg::stap_state_t state_nxt;

  logic [2:0]   irShift_r;
  logic [2:0]   ir_r;
  logic [31:0]  idReg_r;
  logic [118:0] bsr_r;
  logic         bypass_r;
  logic [118:0] pinMeta_r;
  logic [118:0] pinSync_r;
  logic         floatTck_r;
  logic         floatMeta_r;
  logic         selId;
  logic         selBsr;
  logic         serialOut;

  // TAP state sequencing; TMS high five times reaches reset from anywhere
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      stap_pkg::ST_TLR:      state_nxt = tms ? stap_pkg::ST_TLR : stap_pkg::ST_RTI;
      stap_pkg::ST_RTI:      state_nxt = tms ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
      stap_pkg::ST_SEL_DR:   state_nxt = tms ? stap_pkg::ST_SEL_IR : stap_pkg::ST_CAP_DR;
      stap_pkg::ST_CAP_DR:   state_nxt = tms ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
      stap_pkg::ST_SHIFT_DR: state_nxt = tms ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
      stap_pkg::ST_EXIT1_DR: state_nxt = tms ? stap_pkg::ST_UPD_DR : stap_pkg::ST_PAUSE_DR;
      stap_pkg::ST_PAUSE_DR: state_nxt = tms ? stap_pkg::ST_EXIT2_DR : stap_pkg::ST_PAUSE_DR;
      stap_pkg::ST_EXIT2_DR: state_nxt = tms ? stap_pkg::ST_UPD_DR : stap_pkg::ST_SHIFT_DR;
      stap_pkg::ST_UPD_DR:   state_nxt = tms ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
      stap_pkg::ST_SEL_IR:   state_nxt = tms ? stap_pkg::ST_TLR : stap_pkg::ST_CAP_IR;
      stap_pkg::ST_CAP_IR:   state_nxt = tms ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
      stap_pkg::ST_SHIFT_IR: state_nxt = tms ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
      stap_pkg::ST_EXIT1_IR: state_nxt = tms ? stap_pkg::ST_UPD_IR : stap_pkg::ST_PAUSE_IR;
      stap_pkg::ST_PAUSE_IR: state_nxt = tms ? stap_pkg::ST_EXIT2_IR : stap_pkg::ST_PAUSE_IR;
      stap_pkg::ST_EXIT2_IR: state_nxt = tms ? stap_pkg::ST_UPD_IR : stap_pkg::ST_SHIFT_IR;
      stap_pkg::ST_UPD_IR:   state_nxt = tms ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
      default:               state_nxt = stap_pkg::ST_TLR;
    endcase
  end

  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= stap_pkg::ST_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Instruction shift path
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      irShift_r <= stap_pkg::IR_RESET_VAL;
    end else if (state_r == stap_pkg::ST_CAP_IR) begin
      irShift_r <= stap_pkg::IR_CAPTURE_VAL;
    end else if (state_r == stap_pkg::ST_SHIFT_IR) begin
      irShift_r <= {tdi, irShift_r[2:1]};
    end
  end

  // Active instruction
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      ir_r <= stap_pkg::IR_RESET_VAL;
    end else if (state_r == stap_pkg::ST_TLR) begin
      ir_r <= stap_pkg::IR_RESET_VAL;
    end else if (state_r == stap_pkg::ST_UPD_IR) begin
      ir_r <= irShift_r;
    end
  end

  // Data register selection; reserved codes fall back to bypass
  always_comb begin
    selId  = 1'b0;
    selBsr = 1'b0;
    case (ir_r)
      stap_pkg::OP_IDCODE:     selId  = 1'b1;
      stap_pkg::OP_CLK_EXTEST: selBsr = 1'b1;
      stap_pkg::OP_SAMPLE_Z:   selBsr = 1'b1;
      stap_pkg::OP_SAMPLE_PRE: selBsr = 1'b1;
      default:                 selBsr = 1'b0;
    endcase
  end

  // Pin levels come from another domain
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= sramPins;
      pinSync_r <= pinMeta_r;
    end
  end

  // Identification register
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      idReg_r <= stap_pkg::DEVICE_CODE_ROM;
    end else if (selId && state_r == stap_pkg::ST_CAP_DR) begin
      idReg_r <= stap_pkg::DEVICE_CODE_ROM;
    end else if (selId && state_r == stap_pkg::ST_SHIFT_DR) begin
      idReg_r <= {tdi, idReg_r[31:1]};
    end
  end

  // Boundary scan register, bit 0 shifts out first
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      bsr_r <= '0;
    end else if (selBsr && state_r == stap_pkg::ST_CAP_DR) begin
      bsr_r <= pinSync_r;
    end else if (selBsr && state_r == stap_pkg::ST_SHIFT_DR) begin
      bsr_r <= {tdi, bsr_r[118:1]};
    end
  end

  // Bypass cell
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      bypass_r <= 1'b0;
    end else if (state_r == stap_pkg::ST_CAP_DR) begin
      bypass_r <= 1'b0;
    end else if (state_r == stap_pkg::ST_SHIFT_DR) begin
      bypass_r <= tdi;
    end
  end

  always_comb begin
    if (state_r == stap_pkg::ST_SHIFT_IR) begin
      serialOut = irShift_r[0];
    end else if (selId) begin
      serialOut = idReg_r[0];
    end else if (selBsr) begin
      serialOut = bsr_r[0];
    end else begin
      serialOut = bypass_r;
    end
  end

  // Output launched on the falling edge
  always_ff @(negedge tck or negedge rst_b) begin
    if (!rst_b) begin
      tdo <= 1'b0;
    end else begin
      tdo <= serialOut;
    end
  end

  // Driver enable follows the shift states on the same edge
  always_ff @(negedge tck or negedge rst_b) begin
    if (!rst_b) begin
      tdoEn <= 1'b0;
    end else begin
      tdoEn <= (state_r == stap_pkg::ST_SHIFT_DR) || (state_r == stap_pkg::ST_SHIFT_IR);
    end
  end

  // Float request loads with the instruction; tck may stop right after
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      floatTck_r <= 1'b0;
    end else if (state_r == stap_pkg::ST_TLR) begin
      floatTck_r <= 1'b0;
    end else if (state_r == stap_pkg::ST_UPD_IR) begin
      floatTck_r <= (irShift_r == stap_pkg::OP_SAMPLE_Z);
    end
  end

  // Float request crosses to the SRAM clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      floatMeta_r  <= 1'b0;
      sramOutFloat <= 1'b0;
    end else begin
      floatMeta_r  <= floatTck_r;
      sramOutFloat <= floatMeta_r;
    end
  end

endmodule

// ==== verification/stap_tap_sva.sv ====
`timescale 1ns/1ps
module stap_tap_sva (
  input wire logic         ref_clk,
  input wire logic         rst_b,
  input wire logic         tck,
  input wire logic         tms,
  input wire logic         tdi,
  input wire logic         tdo,
  input wire logic         tdoEn,
  input wire logic [118:0] sramPins,
  input wire logic         sramOutFloat
);
  sequence s_rst_rti; tms [*5] ##1 !tms; endsequence
  sequence s_id_dr; s_rst_rti ##1 tms ##1 !tms [*2]; endsequence
  sequence s_ir_sh; s_rst_rti ##1 tms [*2] ##1 !tms [*2]; endsequence
  a_id_first_bit: assert property (@(posedge tck) disable iff (!rst_b)
    s_id_dr |=> tdoEn && tdo == stap_pkg::DEVICE_CODE_ROM[0]) else $error("id bit 0 wrong");
  a_id_second_bit: assert property (@(posedge tck) disable iff (!rst_b)
    s_id_dr ##1 !tms |=> tdo == stap_pkg::DEVICE_CODE_ROM[1]) else $error("id bit 1 wrong");
  a_ir_capture_low: assert property (@(posedge tck) disable iff (!rst_b)
    s_ir_sh |=> tdoEn && tdo == stap_pkg::IR_CAPTURE_VAL[0]) else $error("ir capture wrong");
  a_shift_entry: assert property (@(posedge tck) disable iff (!rst_b)
    $rose(tdoEn) |-> !$past(tms)) else $error("shift entered wrongly");
  a_shift_exit: assert property (@(posedge tck) disable iff (!rst_b)
    tdoEn && tms |=> !tdoEn) else $error("shift not left");
  a_reset_unfloat: assert property (@(posedge tck) disable iff (!rst_b)
    tms [*8] |-> !sramOutFloat) else $error("float kept after reset");
  a_tdo_fall_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tck && $past(tck) |-> $stable(tdo)) else $error("tdo moved while tck high");
  a_float_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(sramOutFloat) |-> !tdoEn) else $error("float rose during shift");
endmodule
bind stap_tap stap_tap_sva chk_u (.ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .sramPins(sramPins), .sramOutFloat(sramOutFloat));

// ==== verification/stap_scan_ctl.sv ====
`timescale 1ns/1ps
module stap_scan_ctl (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoEn
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One tck cycle; tck rests low between frames
  task automatic clk_bit(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #15 tck = 1'b1;
    o = tdoEn ? tdo : ~tdo;
    #15 tck = 1'b0;
  endtask
  task automatic walk(input logic [8:0] v, input int n);
    logic o;
    for (int i = 0; i < n; i++) clk_bit(v[i], 1'b0, o);
  endtask
endmodule

// ==== verification/sram_tap_instruction_decode_bench.sv ====
`timescale 1ns/1ps
module sram_tap_instruction_decode_bench;
  logic         ref_clk  = 1'b0;
  logic         rst_b    = 1'b0;
  logic [118:0] sramPins = '0;
  logic [127:0] r;
  logic         o, d, e;
  logic         q[$];
  wire          tck, tms, tdi, tdo, tdoEn, sramOutFloat;
  int           n_errors = 0;
  int           checks   = 0;
  int           seed     = 35728;
  int           w, n, k;
  logic [2:0]   ops [6]  = '{stap_pkg::OP_IDCODE, stap_pkg::OP_SAMPLE_Z, stap_pkg::OP_SAMPLE_PRE,
    stap_pkg::OP_CLK_EXTEST, stap_pkg::OP_BYPASS, stap_pkg::OP_IDCODE};
  always #5 ref_clk = ~ref_clk;
  stap_tap dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoEn(tdoEn), .sramPins(sramPins), .sramOutFloat(sramOutFloat));
  stap_scan_ctl ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));
  task automatic check(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic float_chk();
    e = ops[k] == stap_pkg::OP_SAMPLE_Z;
    for (w = 0; w < 20 && sramOutFloat !== e; w++) begin
      @(posedge ref_clk);
      #1;
    end
    check("float", sramOutFloat, e);
    if (w == 20) complete_run();
  endtask
  initial begin
    ctl_u.clk_bit(1'b1, 1'b0, o);
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (k = 0; k < 6; k++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      @(posedge ref_clk) sramPins <= r[118:0];
      #3.1 ctl_u.walk(9'h0FF, 9);
      if (k % 5 != 0) begin
        ctl_u.walk(9'h003, 4);
        for (int i = 0; i < 3; i++) begin
          ctl_u.clk_bit(i == 2, ops[k][i], o);
          check("ir_capture", o, stap_pkg::IR_CAPTURE_VAL[i]);
        end
        ctl_u.walk(9'h001, 2);
      end
      float_chk();
      ctl_u.walk(9'h001, 3);
      n = ops[k] == stap_pkg::OP_IDCODE ? 32 : ops[k] == stap_pkg::OP_BYPASS ? 8 : 119;
      q = {1'b0};
      for (int i = 0; i < n; i++) begin
        d = 1'($random(seed));
        q.push_back(d);
        ctl_u.clk_bit(i == n - 1, d, o);
        e = ops[k] == stap_pkg::OP_BYPASS ? q.pop_front() : r[i];
        if (ops[k] == stap_pkg::OP_IDCODE) e = stap_pkg::DEVICE_CODE_ROM[i];
        check("dr_bit", o, e);
      end
      ctl_u.walk(9'h001, 2);
      float_chk();
    end
    complete_run();
  end
endmodule
